// >>> rtl/bccr_pkg.sv
// package: offsets, fields and reset values of the bridge identity and command registers
package bccr_pkg;
  localparam logic [11:0] BCCR_OFF_IDENT   = 12'h000;
  localparam logic [11:0] BCCR_OFF_COMMAND = 12'h004;
  localparam int BCCR_CMD_IO      = 0;
  localparam int BCCR_CMD_MEM     = 1;
  localparam int BCCR_CMD_MASTER  = 2;
  localparam int BCCR_CMD_SPECIAL = 3;
  localparam int BCCR_CMD_MWI     = 4;
  localparam int BCCR_CMD_PALETTE = 5;
  localparam int BCCR_CMD_PARITY  = 6;
  localparam int BCCR_CMD_WAIT    = 7;
  localparam int BCCR_CMD_SYSERR  = 8;
  localparam int BCCR_CMD_FASTB2B = 9;
  localparam int BCCR_CMD_INTDIS  = 10;
  localparam int BCCR_STS_MDPE    = 24;
  localparam logic [15:0] BCCR_CMD_RESET  = 16'h0000;
  localparam logic [15:0] BCCR_CMD_WMASK_FWD = 16'h0147;
  localparam logic [15:0] BCCR_CMD_WMASK_REV = 16'h0567;
  localparam logic [9:0]  BCCR_PAL_MASK_A = 10'h3c6;
  localparam logic [9:0]  BCCR_PAL_DATA_R = 10'h3c8;
  localparam logic [9:0]  BCCR_PAL_DATA_W = 10'h3c9;
  // arbitrary identity values
  localparam logic [15:0] BCCR_MAKER_DEF  = 16'h1a2b;
  localparam logic [15:0] BCCR_PART_DEF   = 16'h3c4d;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bccr_cfg_req_t;

  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic master_en;
    logic palette_en;
    logic syserr_en;
    logic int_block;
  } bccr_enables_t;
endpackage

// >>> rtl/bccr_regs.sv
// bridge configuration identity and command register logic
`timescale 1ns/1ps
// Functional notes
// - fields obey their access type; writing one clears clearable bits, zero leaves them
// - dword zero low half is a fixed read-only maker code
// - dword zero high half is a fixed read-only part code
// - command bit 0 resets low and gates primary I/O response
// - command bit 1 resets low and gates primary memory acceptance
// - command bit 2 gates primary mastering and secondary memory/I/O response
// - split completions may start in reverse split mode regardless of master enable
// - command bit 3 reads zero; no special cycle target
// - command bit 4 reads zero; invalidate writes only when forwarded
// - reverse mode bit 5 enables palette write decode at 3c6h, 3c8h, 3c9h
// - bit 6 enables setting master data parity error on poison or parity
// - bits 7, 9 and 15 to 11 read zero
// - reverse mode bit 10 blocks all four legacy interrupt pins
// - status bit 24 write-one-clear, set only while parity response enabled
module bccr_regs #(
  parameter logic [15:0] MAKER_ID = bccr_pkg::BCCR_MAKER_DEF,
  parameter logic [15:0] PART_ID  = bccr_pkg::BCCR_PART_DEF
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   reverse_mode,
  input  wire bccr_pkg::bccr_cfg_req_t cfg_req,
  output logic                        cfg_ack_q,
  output logic [31:0]                 cfg_rdata_q,
  input  wire logic                   split_mode,
  input  wire logic                   pri_io_req,
  input  wire logic                   pri_mem_req,
  input  wire logic                   fwd_req,
  input  wire logic                   fwd_split_cpl,
  input  wire logic                   fwd_mwi,
  input  wire logic                   sec_req,
  input  wire logic [9:0]             pri_io_wr_addr,
  input  wire logic                   parity_event,
  input  wire logic                   error_event,
  input  wire logic [3:0]             int_req,
  output bccr_pkg::bccr_enables_t     enables_q,
  output logic                        pri_io_claim_q,
  output logic                        pri_mem_claim_q,
  output logic                        pri_master_go_q,
  output logic                        pri_mwi_q,
  output logic                        sec_claim_q,
  output logic                        palette_claim_q,
  output logic                        err_msg_q,
  output logic                        serr_drive_q,
  output logic [3:0]                  int_assert_q
);
  logic [15:0] cmd_q;
  logic        mdpe_q;
  logic [15:0] wmask;
  logic [15:0] be_mask;
  logic        wr_cmd;
  logic        wr_ident;
  logic        any_req;
  logic [15:0] wdat16;
  logic        pal_hit;
  logic        split_bypass;
  logic        err_gated;
  logic        mdpe_set;
  logic        mdpe_clr;

  // request decode
  // the offset compare is on the full byte address, so an access to a
  // byte inside the dword falls to the unmapped path and reads zero
  assign wr_cmd   = cfg_req.wr && (cfg_req.addr == bccr_pkg::BCCR_OFF_COMMAND);
  assign wr_ident = cfg_req.wr && (cfg_req.addr == bccr_pkg::BCCR_OFF_IDENT);
  assign any_req  = cfg_req.rd || cfg_req.wr;

  // byte lanes 0 and 1 carry the command half of the dword
  assign be_mask = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

  // bits 5 and 10 writable only in reverse mode; bits 3,4,7,9,15:11 always zero
  assign wmask = reverse_mode ? bccr_pkg::BCCR_CMD_WMASK_REV
                              : bccr_pkg::BCCR_CMD_WMASK_FWD;

  assign wdat16 = be_mask & cfg_req.wdata[15:0] & wmask;

  // palette decode looks at the low ten address bits only, so the
  // aliases above them hit as well
  assign pal_hit = (pri_io_wr_addr == bccr_pkg::BCCR_PAL_MASK_A)
                || (pri_io_wr_addr == bccr_pkg::BCCR_PAL_DATA_R)
                || (pri_io_wr_addr == bccr_pkg::BCCR_PAL_DATA_W);

  // split completions bypass the master enable only in reverse split mode
  assign split_bypass = reverse_mode && split_mode && fwd_split_cpl;

  // one error event feeds both report paths; the mode picks the path
  assign err_gated = error_event && cmd_q[bccr_pkg::BCCR_CMD_SYSERR];

  // status clear rides on lane 3 of a command write
  assign mdpe_set = parity_event && cmd_q[bccr_pkg::BCCR_CMD_PARITY];
  assign mdpe_clr = wr_cmd && cfg_req.be[3] && cfg_req.wdata[bccr_pkg::BCCR_STS_MDPE];

  // command register; none of its bits are sticky so one reset serves
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_q <= bccr_pkg::BCCR_CMD_RESET;
    end else if (ce && wr_cmd) begin
      cmd_q <= (cmd_q & ~(be_mask & wmask)) | wdat16;
    end
  end

  // master data parity error: set wins over a same-cycle clear, so an
  // event racing the host's clear is never lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mdpe_q <= 1'b0;
    end else if (ce) begin
      if (mdpe_set) begin
        mdpe_q <= 1'b1;
      end else if (mdpe_clr) begin
        mdpe_q <= 1'b0;
      end
    end
  end

  // every accepted request, read or write, gets one ack pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_ack_q <= 1'b0;
    end else if (ce) begin
      cfg_ack_q <= any_req;
    end
  end

  // read data holds until the next read or identity write, which zeroes it; the status half of dword one
  // only carries the parity flag here, the other status fields live
  // elsewhere and read as zero from this block
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (cfg_req.rd) begin
        unique case (cfg_req.addr)
          bccr_pkg::BCCR_OFF_IDENT:   cfg_rdata_q <= {PART_ID, MAKER_ID};
          bccr_pkg::BCCR_OFF_COMMAND: cfg_rdata_q <= {7'h00, mdpe_q, 8'h00, cmd_q};
          default:                    cfg_rdata_q <= 32'h0000_0000;
        endcase
      end else if (wr_ident) begin
        cfg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  // enable copies for the forwarding logic
  // they lag the command register by one cycle; a write that changes an
  // enable is seen downstream one cycle after the ack
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.io_en <= 1'b0;
    end else if (ce) begin
      enables_q.io_en <= cmd_q[bccr_pkg::BCCR_CMD_IO];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.mem_en <= 1'b0;
    end else if (ce) begin
      enables_q.mem_en <= cmd_q[bccr_pkg::BCCR_CMD_MEM];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.master_en <= 1'b0;
    end else if (ce) begin
      enables_q.master_en <= cmd_q[bccr_pkg::BCCR_CMD_MASTER];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.palette_en <= 1'b0;
    end else if (ce) begin
      enables_q.palette_en <= cmd_q[bccr_pkg::BCCR_CMD_PALETTE];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.syserr_en <= 1'b0;
    end else if (ce) begin
      enables_q.syserr_en <= cmd_q[bccr_pkg::BCCR_CMD_SYSERR];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables_q.int_block <= 1'b0;
    end else if (ce) begin
      enables_q.int_block <= cmd_q[bccr_pkg::BCCR_CMD_INTDIS];
    end
  end

  // gated outputs
  // these use the current command value, so each answers one cycle after
  // its qualifying input; registering them keeps the forwarding logic
  // free of paths through the configuration decode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri_io_claim_q <= 1'b0;
    end else if (ce) begin
      pri_io_claim_q <= pri_io_req && cmd_q[bccr_pkg::BCCR_CMD_IO];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri_mem_claim_q <= 1'b0;
    end else if (ce) begin
      pri_mem_claim_q <= pri_mem_req && cmd_q[bccr_pkg::BCCR_CMD_MEM];
    end
  end

  // mastering on the primary, with the split completion escape
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri_master_go_q <= 1'b0;
    end else if (ce) begin
      pri_master_go_q <= fwd_req
                         && (cmd_q[bccr_pkg::BCCR_CMD_MASTER] || split_bypass);
    end
  end

  // invalidate only passes through when forwarded from another master;
  // the bridge never starts one of its own
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri_mwi_q <= 1'b0;
    end else if (ce) begin
      pri_mwi_q <= fwd_mwi && fwd_req && cmd_q[bccr_pkg::BCCR_CMD_MASTER];
    end
  end

  // secondary side response shares the master enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sec_claim_q <= 1'b0;
    end else if (ce) begin
      sec_claim_q <= sec_req && cmd_q[bccr_pkg::BCCR_CMD_MASTER];
    end
  end

  // palette snoop exists in reverse mode only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      palette_claim_q <= 1'b0;
    end else if (ce) begin
      palette_claim_q <= reverse_mode && cmd_q[bccr_pkg::BCCR_CMD_PALETTE]
                         && pri_io_req && pal_hit;
    end
  end

  // forward bridge reports by message
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_msg_q <= 1'b0;
    end else if (ce) begin
      err_msg_q <= !reverse_mode && err_gated;
    end
  end

  // reverse bridge reports on the system error pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serr_drive_q <= 1'b0;
    end else if (ce) begin
      serr_drive_q <= reverse_mode && err_gated;
    end
  end

  // one blocker per legacy interrupt line; the block has effect in
  // reverse mode only, so a stale bit left from that mode is harmless
  for (genvar i = 0; i < 4; i++) begin : g_int
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        int_assert_q[i] <= 1'b0;
      end else if (ce) begin
        int_assert_q[i] <= int_req[i]
                           && !(reverse_mode && cmd_q[bccr_pkg::BCCR_CMD_INTDIS]);
      end
    end
  end
endmodule // bccr_regs

// >>> tb/bccr_regs_chk.sv
// checker: port relations of the bridge command registers
`timescale 1ns/1ps
module bccr_regs_chk #(
  parameter logic [15:0] MAKER_ID = 16'h0000,
  parameter logic [15:0] PART_ID  = 16'h0000
) (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    ce,
  input wire logic                    reverse_mode,
  input wire bccr_pkg::bccr_cfg_req_t cfg_req,
  input wire logic [31:0]             cfg_rdata_q,
  input wire logic                    pri_io_req,
  input wire logic [9:0]              pri_io_wr_addr,
  input wire bccr_pkg::bccr_enables_t enables_q,
  input wire logic                    pri_io_claim_q,
  input wire logic                    palette_claim_q,
  input wire logic [3:0]              int_assert_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic rd_id, rd_cmd;
  assign rd_id = ce && cfg_req.rd && cfg_req.addr == 12'h000;
  assign rd_cmd = ce && cfg_req.rd && cfg_req.addr == 12'h004;
  property p_maker; $past(rd_id) |-> cfg_rdata_q[15:0] == MAKER_ID; endproperty
  a_maker: assert property (p_maker) else $error("maker code wrong");
  property p_part; $past(rd_id) |-> cfg_rdata_q[31:16] == PART_ID; endproperty
  a_part: assert property (p_part) else $error("part code wrong");
  property p_zero; $past(rd_cmd) |-> (cfg_rdata_q & 32'h0000fa98) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("fixed zero bit set");
  property p_en; $past(rd_cmd) |-> enables_q.io_en == cfg_rdata_q[0]
    && enables_q.mem_en == cfg_rdata_q[1] && enables_q.master_en == cfg_rdata_q[2]; endproperty
  a_en: assert property (p_en) else $error("enables differ from command");
  property p_io; $past(ce) |-> pri_io_claim_q == ($past(pri_io_req) && enables_q.io_en); endproperty
  a_io: assert property (p_io) else $error("io claim wrong");
  property p_pal; palette_claim_q |-> enables_q.palette_en
    && $past(pri_io_wr_addr) inside {10'h3c6, 10'h3c8, 10'h3c9}; endproperty
  a_pal: assert property (p_pal) else $error("palette claim wrong");
  property p_palr; palette_claim_q |-> $past(pri_io_req) && $past(reverse_mode); endproperty
  a_palr: assert property (p_palr) else $error("palette claim unrequested");
  property p_int; $past(reverse_mode) && enables_q.int_block |-> int_assert_q == 4'h0; endproperty
  a_int: assert property (p_int) else $error("interrupt not blocked");
  c_pal: cover property (palette_claim_q);
  c_io: cover property (pri_io_claim_q);
  c_id: cover property ($past(rd_id));
endmodule // bccr_regs_chk
bind bccr_regs bccr_regs_chk #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_chk (.*);

// >>> tb/tb.sv
// testbench: command register access and gating
`timescale 1ns/1ps
module tb;
  logic clock = 1'h0, rst = 1'h1, ce = 1'h1, reverse_mode = 1'h0, split_mode = 1'h0;
  logic pri_io_req = 1'h0, pri_mem_req = 1'h0, fwd_req = 1'h0, fwd_split_cpl = 1'h0;
  logic fwd_mwi = 1'h0, sec_req = 1'h0, parity_event = 1'h0, error_event = 1'h0;
  logic [9:0] pri_io_wr_addr = 10'h000;
  logic [3:0] int_req = 4'h0, int_assert_q;
  logic [31:0] cfg_rdata_q;
  logic cfg_ack_q, pri_io_claim_q, pri_mem_claim_q, pri_master_go_q, pri_mwi_q;
  logic sec_claim_q, palette_claim_q, err_msg_q, serr_drive_q;
  bccr_pkg::bccr_cfg_req_t cfg_req = '0;
  bccr_pkg::bccr_enables_t enables_q;
  int err_count = 0, num_checks = 0;
  // mode, address, write data, expected readback
  logic [76:0] rows [5] = '{{1'h0, 12'h004, 32'h0000ffff, 32'h00000147},
    {1'h0, 12'h004, 32'h0, 32'h0}, {1'h1, 12'h004, 32'h0000ffff, 32'h00000567},
    {1'h1, 12'h000, 32'hffffffff, bccr_pkg::BCCR_PART_DEF, bccr_pkg::BCCR_MAKER_DEF},
    {1'h1, 12'h008, 32'hffffffff, 32'h0}};
  bccr_regs uut (.*);
  always #2.5 clock = ~clock;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cfg(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clock);
    cfg_req = {~w, w, a, b, d};
    @(negedge clock);
    cfg_req = '0;
    chk({31'h0, cfg_ack_q}, 32'h1);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'h0;
    cfg(1'h0, 12'h004, 4'hf, 32'h0);
    chk(cfg_rdata_q, 32'h0);
    foreach (rows[i]) begin
      reverse_mode = rows[i][76];
      cfg(1'h1, rows[i][75:64], 4'hf, rows[i][63:32]);
      cfg(1'h0, rows[i][75:64], 4'hf, 32'h0);
      chk(cfg_rdata_q, rows[i][31:0]);
    end
    $display("register rows done");
    {pri_io_req, pri_mem_req, sec_req, pri_io_wr_addr, int_req} = {3'h7, 10'h3c8, 4'hf};
    @(negedge clock);
    chk({pri_io_claim_q, pri_mem_claim_q, sec_claim_q, palette_claim_q, int_assert_q}, 32'hf0);
    cfg(1'h1, 12'h004, 4'hf, 32'h0);
    @(negedge clock);
    chk({pri_io_claim_q, pri_mem_claim_q, sec_claim_q, palette_claim_q, int_assert_q}, 32'h0f);
    $display("gating done");
    cfg(1'h1, 12'h004, 4'hf, 32'h40);
    parity_event = 1'h1;
    @(negedge clock);
    parity_event = 1'h0;
    cfg(1'h0, 12'h004, 4'hf, 32'h0);
    chk(cfg_rdata_q, 32'h01000040);
    cfg(1'h1, 12'h004, 4'h8, 32'h01000040);
    cfg(1'h0, 12'h004, 4'hf, 32'h0);
    chk(cfg_rdata_q, 32'h40);
    $display("parity status done");
    {fwd_req, fwd_mwi, split_mode, fwd_split_cpl, error_event} = 5'h1f;
    @(negedge clock);
    chk({pri_master_go_q, pri_mwi_q, err_msg_q, serr_drive_q}, 32'h8);
    fwd_split_cpl = 1'h0;
    @(negedge clock);
    chk({pri_master_go_q, pri_mwi_q, err_msg_q, serr_drive_q}, 32'h0);
    cfg(1'h1, 12'h004, 4'hf, 32'h104);
    @(negedge clock);
    chk({pri_master_go_q, pri_mwi_q, err_msg_q, serr_drive_q}, 32'hd);
    chk({26'h0, enables_q}, 32'h0a);
    reverse_mode = 1'h0;
    @(negedge clock);
    chk({pri_master_go_q, pri_mwi_q, err_msg_q, serr_drive_q}, 32'he);
    $display("master and error paths done");
    rst = 1'h1;
    @(negedge clock);
    @(negedge clock);
    chk({27'h0, pri_master_go_q, pri_mwi_q, err_msg_q, cfg_ack_q, serr_drive_q}, 32'h0);
    chk({26'h0, enables_q}, 32'h0);
    rst = 1'h0;
    cfg(1'h0, 12'h004, 4'hf, 32'h0);
    chk(cfg_rdata_q, 32'h0);
    $display("mid-run reset done");
    final_report();
  end
endmodule // tb
